// ==== sbl_assertions.sv ====
// port checker for the serial boot code loader
`timescale 1ns/1ns
module sbl_checker
(
  input wire i_clk, // clock
  input wire i_reset, // reset
  input wire i_serial_out_pin, // strap
  input wire i_tx_ready, // tx taken
  input wire i_wd_call_ack, // wd ack
  input wire o_tx_valid, // tx valid
  input wire [7:0] o_tx_data, // tx byte
  input wire o_serial_enable, // serial on
  input wire [7:0] o_char_setup, // format
  input wire [7:0] o_clock_setup, // clocks
  input wire [7:0] o_baud_div, // divider
  input wire [7:0] o_mode_setup, // mode
  input wire [7:0] o_vector_base, // vectors
  input wire [7:0] o_irq_priority, // priority
  input wire [7:0] o_segment_select, // remap
  input wire o_pin_alt, // pin function
  input wire o_jump, // jump
  input wire [23:0] o_jump_addr, // entry
  input wire o_user_start, // start
  input wire o_halt, // halted
  input wire o_wd_call, // wd call
  input wire [23:0] o_wd_target // wd target
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////
  // serial unit setup, strap response, transmit, jump, halt, start and watchdog calls
  AST_SETUP: assert property (
    o_serial_enable |-> o_char_setup == 8'h83 && o_clock_setup == 8'hE8
    && o_baud_div == 8'h04 && o_mode_setup == 8'h83)
    else $error("serial setup wrong");
  AST_VEC: assert property (
    o_serial_enable |-> o_vector_base == 8'h10 && o_irq_priority == 8'h00
    && o_segment_select == 8'h23 && o_pin_alt)
    else $error("vectors or remap wrong");
  AST_STRAP_LOW: assert property (
    $fell(i_reset) && !i_serial_out_pin |-> ##[0:3] o_serial_enable)
    else $error("update not entered");
  AST_STRAP_HIGH: assert property (
    $fell(i_reset) && i_serial_out_pin |-> !o_serial_enable [*8])
    else $error("serial enabled with strap high");
  AST_SYNC: assert property (
    $rose(o_serial_enable) |-> ##[0:3] (o_tx_valid && o_tx_data == 8'h25))
    else $error("no sync byte");
  AST_TX_HOLD: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx byte dropped");
  AST_JUMP: assert property (
    o_jump |-> o_jump_addr == 24'h20_0018 && !o_halt)
    else $error("bad entry address");
  AST_HALT: assert property (
    o_halt |=> o_halt && !o_tx_valid && !o_jump && !o_user_start)
    else $error("activity after halt");
  AST_START: assert property (
    o_user_start |=> !o_user_start && !o_serial_enable)
    else $error("start not a pulse");
  AST_WD_HOLD: assert property (
    o_wd_call && !i_wd_call_ack |=> o_wd_call)
    else $error("wd call dropped");
  AST_WD_BLANK: assert property (
    o_wd_call |-> o_wd_target[15:0] != 16'hFFFF)
    else $error("wd call to blank address");
  // main scenarios reached
  COV_JUMP: cover property (o_jump);
  COV_HALT: cover property ($rose(o_halt));
  COV_WD: cover property ($rose(o_wd_call));
  COV_START: cover property (o_user_start);
endmodule

// ==== sbl_consts.vh ====
// constants for the serial boot code loader
`ifndef SBL_CONSTS_VH
`define SBL_CONSTS_VH
`define SBL_SYNC_BYTE 8'h25
`define SBL_MATCH_BYTE 8'h23
`define SBL_READY_BYTE 8'h21
`define SBL_BLANK_VECTOR 16'hFFFF
`define SBL_FILL_BYTE 8'hFF
`define SBL_MAX_LOAD 13'h1000
`define SBL_RAM_START 24'h20_0010
`define SBL_ENTRY_ADDR 24'h20_0018
`define SBL_RAM_WORDS 13'h1000
`define SBL_CHAR_SETUP 8'h83
`define SBL_CLOCK_SETUP 8'hE8
`define SBL_BAUD_DIV 8'h04
`define SBL_SYNC_MODE 8'h83
`define SBL_VECTOR_BASE 8'h10
`define SBL_IRQ_PRIORITY 8'h00
`define SBL_SEGMENT_SELECT 8'h23
`define SBL_VEC_RESET_LO 24'h00_0000
`define SBL_VEC_RESET_HI 24'h00_0001
`define SBL_WD_ADDR_LO 24'h00_0006
`define SBL_WD_ADDR_HI 24'h00_0007
`define SBL_WD_RATE 24'h00_0008
`define SBL_WD_SEG 24'h00_0009
`define SBL_CLK_HZ 20000000
`define SBL_TIMEOUT_MS 10
`define SBL_REF_OSC_HZ 4000000
`define SBL_WD_REF_HZ 2000000
// match wait: 10 ms counted in cycles of the 20 MHz clock
`define SBL_TIMEOUT_CYCLES 18'h3_0D40
// one millisecond counted in cycles of the 20 MHz clock
`define SBL_MS_CYCLES 15'h4E20
`endif

// ==== sbl_host_model.sv ====
// behavioural programming host on the serial link
`timescale 1ns/1ns
module sbl_host_model
(
  input wire i_clk, // clock
  input wire o_tx_valid, // loader offers byte
  input wire [7:0] o_tx_data, // loader byte
  output reg i_tx_ready, // host takes byte
  output reg i_rx_valid, // host byte strobe
  output reg [7:0] i_rx_data // host byte
);
  byte q[$];
  int grp[$];
  byte log[$];
  int stall = 0;
  int k;
  ////////////////////////////////////////////////////////////////////////////
  // take each prompt, then answer with the next group of bytes
  initial
  begin
    i_tx_ready = 0;
    i_rx_valid = 0;
    i_rx_data = 8'h5A;
    forever
    begin
      @(posedge i_clk);
      if (o_tx_valid)
      begin
        repeat (stall) @(posedge i_clk);
        i_tx_ready <= 1;
        @(posedge i_clk);
        log.push_back(o_tx_data);
        i_tx_ready <= 0;
        k = grp.size() ? grp.pop_front() : 1;
        // match, count, payload, confirm
        repeat (k)
        begin
          repeat (3) @(posedge i_clk);
          if (q.size())
          begin
            i_rx_valid <= 1;
            i_rx_data <= q.pop_front();
            @(posedge i_clk);
            i_rx_valid <= 0;
            i_rx_data <= ~i_rx_data; // released line shows no stale byte
          end
        end
      end
    end
  end
endmodule

// ==== sbl_serial_boot_loader.v ====
// serial boot code loader: strap check, serial load, ram fill, watchdog calls
`timescale 1ns/1ns
// Functional notes
// - after reset sample serial_out_pin; low requests update, else read vector
// - blank vector with pin high halts until hardware reset
// - on update enable serial unit synchronous, send sync byte
// - host answers match byte; device waits a bounded time
// - no match within timeout abandons update, resumes power-on path
// - after match send ready byte
// - host sends two count bytes, count at most 4 Kbytes
// - each payload byte preceded by ready byte, stored from ram start
// - after payload send ready; host confirms with non-sync byte
// - fill unused ram with ones, then jump to fixed entry
// - after loaded routine completes, halt until hardware reset
// - serial setup: 8 bits, synchronous, divider 4, ext rx clock
// - serial vectors at priority 0 from vector base
// - remap interrupts to boot area, pins to serial alternates
// - call watchdog routine at least once per emulated write
// - repeat watchdog call at rate byte milliseconds on long writes
// - watchdog address all ones means no call
module sbl_serial_boot_loader
(
  input wire i_clk, // system clock, 20 MHz
  input wire i_reset, // synchronous reset, active high
  input wire i_serial_out_pin, // strap level of serial_out_pin
  input wire [7:0] i_flash_data, // flash read data
  input wire i_rx_valid, // received byte strobe
  input wire [7:0] i_rx_data, // received byte
  input wire i_tx_ready, // serial unit can take a byte
  input wire i_routine_done, // loaded routine finished
  input wire i_ee_write_busy, // emulated eeprom write in progress
  input wire i_wd_call_ack, // user watchdog routine returned
  output reg [23:0] o_flash_addr, // flash read address
  output reg o_tx_valid, // byte offered to serial unit
  output reg [7:0] o_tx_data, // byte to send
  output reg o_serial_enable, // serial unit enabled
  output reg [7:0] o_char_setup, // character format setting
  output reg [7:0] o_clock_setup, // clock source setting
  output reg [7:0] o_baud_div, // baud divider
  output reg [7:0] o_mode_setup, // synchronous mode setting
  output reg [7:0] o_vector_base, // serial vector base
  output reg [7:0] o_irq_priority, // serial interrupt priority
  output reg [7:0] o_segment_select, // interrupt segment select
  output reg o_pin_alt, // serial pins in alternate function
  output reg o_ram_we, // ram write strobe
  output reg [11:0] o_ram_addr, // ram word offset from start
  output reg [7:0] o_ram_wdata, // ram write data
  output reg o_jump, // pulse: execute at entry address
  output reg [23:0] o_jump_addr, // entry address
  output reg o_user_start, // pulse: normal start-up
  output reg [15:0] o_user_vector, // user reset vector
  output reg o_halt, // device halted
  output reg o_wd_call, // call user watchdog routine
  output reg [23:0] o_wd_target // segment and address of routine
);
`include "sbl_consts.vh"

localparam S_STRAP = 4'h0, S_VEC_LO = 4'h1, S_VEC_HI = 4'h2;
localparam S_SEND = 4'h3, S_MATCH = 4'h4, S_CNT_HI = 4'h5;
localparam S_CNT_LO = 4'h6, S_DATA = 4'h7, S_CONFIRM = 4'h8;
localparam S_FILL = 4'h9, S_RUN = 4'hA, S_HALT = 4'hB;
localparam S_WD_PARAM = 4'hC, S_USER = 4'hD;
localparam [17:0] TIMEOUT_CYC = `SBL_TIMEOUT_CYCLES;
localparam [14:0] MS_CYC = `SBL_MS_CYCLES;

reg [3:0] state, after_send;
reg [17:0] timer;
reg [12:0] count, index;
reg [1:0] prm;
reg [7:0] rate, rate_left;
reg [14:0] ms_timer;
reg wd_enable, wd_pending, ee_prev;

// two-entry transmit buffer: a stalled serial unit loses no byte
reg [7:0] buf_data0, buf_data1;
reg [1:0] buf_count;
reg push;
reg [7:0] push_data;
wire buf_ready = (buf_count != 2'd2);
wire pop = o_tx_valid && i_tx_ready;

always @(posedge i_clk)
begin
  if (i_reset)
  begin
    buf_count <= 2'd0;
    buf_data0 <= 8'h00;
    buf_data1 <= 8'h00;
    o_tx_valid <= 1'b0;
    o_tx_data <= 8'h00;
  end
  else
  begin
    case ({push, pop})
      2'b10:
      begin
        if (buf_count == 2'd0)
          buf_data0 <= push_data;
        else
          buf_data1 <= push_data;
        buf_count <= buf_count + 2'd1;
      end
      2'b01:
      begin
        buf_data0 <= buf_data1;
        buf_count <= buf_count - 2'd1;
      end
      2'b11:
      begin
        if (buf_count == 2'd1)
          buf_data0 <= push_data;
        else
        begin
          buf_data0 <= buf_data1;
          buf_data1 <= push_data;
        end
      end
      default: buf_count <= buf_count;
    endcase
    o_tx_valid <= push || (buf_count != 2'd0 && !(pop && buf_count == 2'd1));
    if (pop && buf_count == 2'd2)
      o_tx_data <= buf_data1;
    else if (pop || buf_count == 2'd0)
      o_tx_data <= push_data;
    else
      o_tx_data <= buf_data0;
  end
end

////////////////////////////////////////////////////////////////////////////
// loader sequence
always @(posedge i_clk)
begin
  push <= 1'b0;
  o_ram_we <= 1'b0;
  o_jump <= 1'b0;
  o_user_start <= 1'b0;
  if (i_reset)
  begin
    state <= S_STRAP;
    after_send <= S_MATCH;
    timer <= 18'h0_0000;
    count <= 13'h0000;
    index <= 13'h0000;
    prm <= 2'd0;
    rate <= 8'h00;
    wd_enable <= 1'b0;
    push_data <= 8'h00;
    o_flash_addr <= 24'h00_0000;
    o_serial_enable <= 1'b0;
    o_char_setup <= 8'h00;
    o_clock_setup <= 8'h00;
    o_baud_div <= 8'h00;
    o_mode_setup <= 8'h00;
    o_vector_base <= 8'h00;
    o_irq_priority <= 8'h00;
    o_segment_select <= 8'h00;
    o_pin_alt <= 1'b0;
    o_ram_addr <= 12'h000;
    o_ram_wdata <= 8'h00;
    o_jump_addr <= 24'h00_0000;
    o_user_vector <= 16'h0000;
    o_halt <= 1'b0;
    o_wd_target <= 24'h00_0000;
  end
  else
  begin
    case (state)
      S_STRAP:
      begin
        if (!i_serial_out_pin)
        begin
          o_serial_enable <= 1'b1;
          o_char_setup <= `SBL_CHAR_SETUP;
          o_clock_setup <= `SBL_CLOCK_SETUP;
          o_baud_div <= `SBL_BAUD_DIV;
          o_mode_setup <= `SBL_SYNC_MODE;
          o_vector_base <= `SBL_VECTOR_BASE;
          o_irq_priority <= `SBL_IRQ_PRIORITY;
          o_segment_select <= `SBL_SEGMENT_SELECT;
          o_pin_alt <= 1'b1;
          push_data <= `SBL_SYNC_BYTE;
          state <= S_SEND;
        end
        else
        begin
          o_flash_addr <= `SBL_VEC_RESET_LO;
          state <= S_VEC_LO;
        end
      end
      S_VEC_LO:
      begin
        o_user_vector[15:8] <= i_flash_data;
        o_flash_addr <= `SBL_VEC_RESET_HI;
        state <= S_VEC_HI;
      end
      S_VEC_HI:
      begin
        o_user_vector[7:0] <= i_flash_data;
        if ({o_user_vector[15:8], i_flash_data} == `SBL_BLANK_VECTOR)
        begin
          o_halt <= 1'b1;
          state <= S_HALT;
        end
        else
        begin
          o_flash_addr <= `SBL_WD_ADDR_LO;
          state <= S_WD_PARAM;
        end
      end
      S_WD_PARAM:
      begin
        // one flash byte per cycle from the watchdog parameter table
        case (prm)
          2'd0: o_wd_target[15:8] <= i_flash_data;
          2'd1: o_wd_target[7:0] <= i_flash_data;
          2'd2: rate <= i_flash_data;
          default: o_wd_target[23:16] <= i_flash_data;
        endcase
        o_flash_addr <= o_flash_addr + 24'h00_0001;
        prm <= prm + 2'd1;
        if (prm == 2'd3)
        begin
          wd_enable <= (o_wd_target[15:0] != `SBL_BLANK_VECTOR);
          o_user_start <= 1'b1;
          state <= S_USER;
        end
      end
      S_SEND:
      begin
        if (buf_ready)
        begin
          push <= 1'b1;
          state <= after_send;
        end
      end
      S_MATCH:
      begin
        timer <= timer + 18'h0_0001;
        if (i_rx_valid && i_rx_data == `SBL_MATCH_BYTE)
        begin
          push_data <= `SBL_READY_BYTE;
          after_send <= S_CNT_HI;
          state <= S_SEND;
        end
        else if (timer >= TIMEOUT_CYC - 18'h0_0001)
        begin
          o_serial_enable <= 1'b0;
          o_pin_alt <= 1'b0;
          o_flash_addr <= `SBL_VEC_RESET_LO;
          state <= S_VEC_LO;
        end
      end
      S_CNT_HI:
        if (i_rx_valid)
        begin
          count[12:8] <= i_rx_data[4:0];
          state <= S_CNT_LO;
        end
      S_CNT_LO:
        if (i_rx_valid)
        begin
          // clamp to the ram size so the fill never wraps
          if ({count[12:8], i_rx_data} > `SBL_MAX_LOAD)
            count <= `SBL_MAX_LOAD;
          else
            count <= {count[12:8], i_rx_data};
          index <= 13'h0000;
          push_data <= `SBL_READY_BYTE;
          after_send <= (count[12:8] == 5'h00 && i_rx_data == 8'h00)
            ? S_CONFIRM : S_DATA;
          state <= S_SEND;
        end
      S_DATA:
        if (i_rx_valid)
        begin
          o_ram_we <= 1'b1;
          o_ram_addr <= index[11:0];
          o_ram_wdata <= i_rx_data;
          index <= index + 13'h0001;
          push_data <= `SBL_READY_BYTE;
          after_send <= (index + 13'h0001 == count) ? S_CONFIRM : S_DATA;
          state <= S_SEND;
        end
      S_CONFIRM:
        if (i_rx_valid && i_rx_data != `SBL_SYNC_BYTE)
          state <= S_FILL;
      S_FILL:
      begin
        if (index == `SBL_RAM_WORDS)
        begin
          o_jump <= 1'b1;
          o_jump_addr <= `SBL_ENTRY_ADDR;
          state <= S_RUN;
        end
        else
        begin
          o_ram_we <= 1'b1;
          o_ram_addr <= index[11:0];
          o_ram_wdata <= `SBL_FILL_BYTE;
          index <= index + 13'h0001;
        end
      end
      S_RUN:
        if (i_routine_done)
        begin
          o_halt <= 1'b1;
          state <= S_HALT;
        end
      S_USER, S_HALT:
        state <= state;
      default:
        state <= S_HALT;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// watchdog refresh calls during emulated eeprom writes
always @(posedge i_clk)
begin
  if (i_reset)
  begin
    o_wd_call <= 1'b0;
    wd_pending <= 1'b0;
    ee_prev <= 1'b0;
    rate_left <= 8'h00;
    ms_timer <= 15'h0000;
  end
  else
  begin
    ee_prev <= i_ee_write_busy;
    if (i_wd_call_ack)
      o_wd_call <= 1'b0;
    else if (wd_pending)
      o_wd_call <= 1'b1;
    if (o_wd_call && i_wd_call_ack)
      wd_pending <= 1'b0;
    if (!wd_enable)
      wd_pending <= 1'b0;
    else if (i_ee_write_busy && !ee_prev)
    begin
      wd_pending <= 1'b1;
      rate_left <= rate;
      ms_timer <= 15'h0000;
    end
    else if (i_ee_write_busy && rate != 8'h00)
    begin
      if (ms_timer == MS_CYC - 15'h0001)
      begin
        ms_timer <= 15'h0000;
        if (rate_left <= 8'h01)
        begin
          wd_pending <= 1'b1;
          rate_left <= rate;
        end
        else
          rate_left <= rate_left - 8'h01;
      end
      else
        ms_timer <= ms_timer + 15'h0001;
    end
  end
end

endmodule

// ==== sbl_serial_boot_loader_test.sv ====
// self-checking bench for the serial boot code loader
`timescale 1ns/1ns
module sbl_serial_boot_loader_test;
  reg i_clk, i_reset, i_serial_out_pin, i_routine_done;
  reg i_ee_write_busy, i_wd_call_ack;
  wire i_rx_valid, i_tx_ready, o_tx_valid, o_serial_enable, o_pin_alt;
  wire o_ram_we, o_jump, o_user_start, o_halt, o_wd_call;
  wire [7:0] i_rx_data, o_tx_data, o_char_setup, o_clock_setup, o_baud_div;
  wire [7:0] o_mode_setup, o_vector_base, o_irq_priority, o_segment_select;
  wire [7:0] o_ram_wdata;
  wire [23:0] o_flash_addr, o_jump_addr, o_wd_target;
  wire [11:0] o_ram_addr;
  wire [15:0] o_user_vector;
  reg [7:0] fl [0:15];
  wire [7:0] i_flash_data = fl[o_flash_addr[3:0]]; // answers in same cycle
  reg [7:0] ram [0:4095];
  int nwr, njump, nstart, i;
  int n_errors = 0;
  int checks_done = 0;
  sbl_serial_boot_loader i_dut (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_serial_out_pin(i_serial_out_pin),
    .i_flash_data(i_flash_data),
    .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data),
    .i_tx_ready(i_tx_ready),
    .i_routine_done(i_routine_done),
    .i_ee_write_busy(i_ee_write_busy),
    .i_wd_call_ack(i_wd_call_ack),
    .o_flash_addr(o_flash_addr),
    .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data),
    .o_serial_enable(o_serial_enable),
    .o_char_setup(o_char_setup),
    .o_clock_setup(o_clock_setup),
    .o_baud_div(o_baud_div),
    .o_mode_setup(o_mode_setup),
    .o_vector_base(o_vector_base),
    .o_irq_priority(o_irq_priority),
    .o_segment_select(o_segment_select),
    .o_pin_alt(o_pin_alt),
    .o_ram_we(o_ram_we),
    .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata),
    .o_jump(o_jump),
    .o_jump_addr(o_jump_addr),
    .o_user_start(o_user_start),
    .o_user_vector(o_user_vector),
    .o_halt(o_halt),
    .o_wd_call(o_wd_call),
    .o_wd_target(o_wd_target)
  );
  sbl_host_model i_host (
    .i_clk(i_clk),
    .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready),
    .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // clock, flash and ram shadows
  initial
  begin
    i_clk = 0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (o_ram_we) ram[o_ram_addr] <= o_ram_wdata;
    if (i_reset)
    begin
      nwr <= 0;
      njump <= 0;
      nstart <= 0;
    end
    else
    begin
      nwr <= nwr + o_ram_we;
      njump <= njump + o_jump;
      nstart <= nstart + o_user_start;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task chk(input bit ok, input string m);
    checks_done++;
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rst(input bit strap);
    i_serial_out_pin <= strap;
    i_reset <= 1;
    repeat (8) @(posedge i_clk);
    i_reset <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_blank;
    foreach (fl[j]) fl[j] <= 8'hFF;
    rst(1);
    repeat (30) @(posedge i_clk);
    chk(o_halt === 1'b1 && nstart == 0, "blank flash not halted");
  endtask
  task t_start(input [15:0] wd);
    fl[0] <= 8'h12;
    fl[1] <= 8'h34;
    {fl[6], fl[7], fl[8], fl[9]} <= {wd, 8'h01, 8'h3C};
    rst(1);
    for (i = 0; i < 50 && nstart == 0; i++) @(posedge i_clk);
    chk(nstart == 1 && o_user_vector === 16'h1234, "start");
    i_ee_write_busy <= 1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk(o_wd_call === (wd != 16'hFFFF), "wd call");
    if (wd != 16'hFFFF)
    begin
      chk(o_wd_target === {8'h3C, wd}, "wd target");
      @(posedge i_clk);
      i_wd_call_ack <= 1;
      @(posedge i_clk);
      i_wd_call_ack <= 0;
      @(posedge i_clk);
      for (i = 0; i < 20100 && o_wd_call !== 1'b1; i++) @(posedge i_clk);
      chk(i > 19900 && i < 20010, "wd repeat period");
      i_wd_call_ack <= 1;
      @(posedge i_clk);
      i_wd_call_ack <= 0;
    end
    i_ee_write_busy <= 0;
  endtask
  task t_load(input int n, input int st);
    i_host.log.delete();
    i_host.stall = st;
    i_host.q = {8'h55, 8'h23, 8'h00, 8'(n)};
    i_host.grp = {2, 2};
    for (i = 0; i < n; i++)
    begin
      i_host.q.push_back(8'(i * 7 + 1));
      i_host.grp.push_back(1);
    end
    i_host.q.push_back(8'h25);
    i_host.q.push_back(8'h00);
    i_host.grp.push_back(2);
    rst(0);
    for (i = 0; i < 20000 && njump == 0; i++) @(posedge i_clk);
    chk(njump == 1 && nwr == 4096, "load did not finish");
    chk(i_host.log.size() == n + 3, "prompt count");
    foreach (i_host.log[j])
      chk(i_host.log[j] == (j ? 8'h21 : 8'h25), "prompt byte");
    for (i = 0; i < 4096; i++)
      chk(ram[i] === (i < n ? 8'(i * 7 + 1) : 8'hFF), "ram");
    i_routine_done <= 1;
    @(posedge i_clk);
    i_routine_done <= 0;
    repeat (3) @(posedge i_clk);
    chk(o_halt === 1'b1, "no halt after routine");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    i_reset = 1;
    i_serial_out_pin = 1;
    i_routine_done = 0;
    i_ee_write_busy = 0;
    i_wd_call_ack = 0;
    t_blank;
    t_start(16'h4567);
    t_start(16'hFFFF);
    t_load(0, 0);
    t_load(6, 3);
    close_out;
  end
  initial
  begin
    #2500000;
    n_errors++;
    close_out;
  end
endmodule
bind sbl_serial_boot_loader sbl_checker i_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_serial_out_pin(i_serial_out_pin),
  .i_tx_ready(i_tx_ready),
  .i_wd_call_ack(i_wd_call_ack),
  .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data),
  .o_serial_enable(o_serial_enable),
  .o_char_setup(o_char_setup),
  .o_clock_setup(o_clock_setup),
  .o_baud_div(o_baud_div),
  .o_mode_setup(o_mode_setup),
  .o_vector_base(o_vector_base),
  .o_irq_priority(o_irq_priority),
  .o_segment_select(o_segment_select),
  .o_pin_alt(o_pin_alt),
  .o_jump(o_jump),
  .o_jump_addr(o_jump_addr),
  .o_user_start(o_user_start),
  .o_halt(o_halt),
  .o_wd_call(o_wd_call),
  .o_wd_target(o_wd_target)
);
